// ==== design/fcsu_cfg.svh ====
// Constants for the flash command controller: register offsets, field
// positions, reset values, command codes and timing counts.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef FCSU_CFG_SVH
`define FCSU_CFG_SVH

// Register byte offsets on the Wishbone slave.
`define FCSU_OFS_CTRL     4'h0
`define FCSU_OFS_ADDR     4'h4
`define FCSU_OFS_WDATA    4'h8
`define FCSU_OFS_RESULT   4'hC
`define FCSU_OFS_IRQ_STAT 5'h10
`define FCSU_OFS_IRQ_MASK 5'h14
`define FCSU_OFS_PINS     5'h18

// Control register: operation code in bits 3:0, go bit 8.
`define FCSU_CTRL_GO_BIT  8
// Result register: busy bit 31, last status byte 7:0, read word 23:8.
`define FCSU_RES_BUSY_BIT 31

// Flash status byte fields.
`define FCSU_SR_READY     7
`define FCSU_SR_PAUSED    6
`define FCSU_SR_ERASE_ERR 5
`define FCSU_SR_PROG_ERR  4
`define FCSU_SR_VPP_LOW   3
`define FCSU_SR_USED_MASK 8'hF8

// Command codes written on the low data byte.
`define FCSU_CMD_READ_ARRAY 8'hFF
`define FCSU_CMD_IDENT      8'h90
`define FCSU_CMD_READ_STAT  8'h70
`define FCSU_CMD_CLEAR_STAT 8'h50
`define FCSU_CMD_PROGRAM    8'h40
`define FCSU_CMD_PROGRAM_2  8'h10
`define FCSU_CMD_ERASE      8'h20
`define FCSU_CMD_CONFIRM    8'hD0
`define FCSU_CMD_SUSPEND    8'hB0

// Strobe timing: each phase of a flash bus cycle, in ns and in cycles.
`define FCSU_CLK_NS       40
`define FCSU_PHASE_NS     120
`define FCSU_PHASE_CYC    ((`FCSU_PHASE_NS + `FCSU_CLK_NS - 1) / `FCSU_CLK_NS)

// Reset values.
`define FCSU_MASK_RESET   4'h0

`endif

// ==== design/fcsu_pkg.sv ====
// Types of the flash command controller.
// Assumes nothing beyond a SystemVerilog compiler.
package fcsu_pkg;

  typedef enum logic [3:0] {
    FCSU_OP_READ_ARRAY = 4'h0,
    FCSU_OP_IDENT      = 4'h1,
    FCSU_OP_READ_STAT  = 4'h2,
    FCSU_OP_CLEAR_STAT = 4'h3,
    FCSU_OP_PROGRAM    = 4'h4,
    FCSU_OP_ERASE      = 4'h5,
    FCSU_OP_SUSPEND    = 4'h6,
    FCSU_OP_RESUME     = 4'h7,
    FCSU_OP_READ_WORD  = 4'h8
  } fcsu_op_t;

  typedef enum logic [5:0] {
    FCSU_ST_IDLE  = 6'h01,
    FCSU_ST_SETUP = 6'h02,
    FCSU_ST_STRB  = 6'h04,
    FCSU_ST_HOLD  = 6'h08,
    FCSU_ST_GAP   = 6'h10,
    FCSU_ST_DONE  = 6'h20
  } fcsu_state_t;

endpackage : fcsu_pkg

// ==== design/fcsu_ctrl.sv ====
// Host-side controller for an asynchronous boot-block flash memory.
// Assumes a 25 MHz clock, a classic Wishbone master, and a flash part
// wired to the pins below; the data bus is resolved by the testbench.
//
// What this block does
// - Identifier is one write of 90h, then one read; address bit 0 picks maker or part code.
// - Status read is one write of 70h, then reads at any address.
// - Program is two writes: 40h (10h is not used), then data at target.
// - The program data write carries target address and data together.
// - Block erase is 20h then confirm D0h, both at an in-block address.
// - Upper data byte of command writes is driven to a valid level.
// - Status bit 7 is ready; host checks it before the error bits.
// - Status bits 2 to 0 are reserved and masked by the host.
//
// The address map and the Wishbone slave port are this design's own decisions.

`timescale 1ns/1ns
`default_nettype none
`include "fcsu_cfg.svh"

module fcsu_ctrl
  import fcsu_pkg::*;
#(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  // System.
  input  wire logic              clock,
  input  wire logic              reset,
  // Wishbone slave.
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [4:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  // Interrupt.
  output var  logic              irq,
  // Flash pins.
  output var  logic [ADDR_W-1:0] flash_addr,
  input  wire logic [DATA_W-1:0] flash_dq_i,
  output var  logic [DATA_W-1:0] flash_dq_o,
  output var  logic              flash_dq_oe,
  output var  logic              flash_ce_n,
  output var  logic              flash_oe_n,
  output var  logic              flash_we_n,
  output var  logic              reset_powerdown_n,
  output var  logic              flash_wp_n
);

  localparam logic [7:0] PHASE = 8'(`FCSU_PHASE_CYC);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic              wr_hit;
  logic              rd_hit;
  logic [3:0]        op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [7:0]        status_r;
  logic [DATA_W-1:0] rword_r;
  logic [3:0]        ist_r;
  logic [3:0]        imask_r;
  logic [1:0]        pins_r;
  logic              busy_r;
  logic              go;

  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  // A start request while busy is dropped; software polls the busy bit.
  assign go     = wr_hit && wb_adr_i == 5'(`FCSU_OFS_CTRL) && wb_sel_i[1]
                  && wb_dat_i[`FCSU_CTRL_GO_BIT] && !busy_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_hit) begin
      case (wb_adr_i)
        5'(`FCSU_OFS_CTRL):     wb_dat_o <= {28'h000_0000, op_r};
        5'(`FCSU_OFS_ADDR):     wb_dat_o <= 32'(addr_r);
        5'(`FCSU_OFS_WDATA):    wb_dat_o <= 32'(wdata_r);
        5'(`FCSU_OFS_RESULT):   wb_dat_o <= {busy_r, 7'h00,
                                            8'(rword_r >> 8),
                                            8'(rword_r), status_r};
        `FCSU_OFS_IRQ_STAT:     wb_dat_o <= {28'h000_0000, ist_r};
        `FCSU_OFS_IRQ_MASK:     wb_dat_o <= {28'h000_0000, imask_r};
        `FCSU_OFS_PINS:         wb_dat_o <= {30'h0000_0000, pins_r};
        default:                wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      op_r    <= 4'h0;
      addr_r  <= '0;
      wdata_r <= '0;
      imask_r <= `FCSU_MASK_RESET;
      pins_r  <= 2'h0;
    end else if (wr_hit) begin
      case (wb_adr_i)
        5'(`FCSU_OFS_CTRL):  if (!busy_r) op_r <= wb_dat_i[3:0];
        5'(`FCSU_OFS_ADDR):  addr_r  <= wb_dat_i[ADDR_W-1:0];
        5'(`FCSU_OFS_WDATA): wdata_r <= wb_dat_i[DATA_W-1:0];
        `FCSU_OFS_IRQ_MASK:  imask_r <= wb_dat_i[3:0];
        `FCSU_OFS_PINS:      pins_r  <= wb_dat_i[1:0];
        default:             ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequence plan: each operation is one or two flash bus cycles.

  function automatic logic [7:0] first_code(input logic [3:0] op);
    case (op)
      FCSU_OP_IDENT:      first_code = `FCSU_CMD_IDENT;
      FCSU_OP_READ_STAT:  first_code = `FCSU_CMD_READ_STAT;
      FCSU_OP_CLEAR_STAT: first_code = `FCSU_CMD_CLEAR_STAT;
      FCSU_OP_PROGRAM:    first_code = `FCSU_CMD_PROGRAM;
      FCSU_OP_ERASE:      first_code = `FCSU_CMD_ERASE;
      FCSU_OP_SUSPEND:    first_code = `FCSU_CMD_SUSPEND;
      FCSU_OP_RESUME:     first_code = `FCSU_CMD_CONFIRM;
      default:            first_code = `FCSU_CMD_READ_ARRAY;
    endcase
  endfunction : first_code

  // Ops that need a second cycle: identifier read, status read, program,
  // erase confirm.  Read word is a single read cycle.
  function automatic logic two_cycles(input logic [3:0] op);
    two_cycles = op == FCSU_OP_IDENT || op == FCSU_OP_READ_STAT ||
                 op == FCSU_OP_PROGRAM || op == FCSU_OP_ERASE;
  endfunction : two_cycles

  fcsu_state_t state_r;
  logic [7:0]  cnt_r;
  logic        second_r;
  logic        is_read;
  logic        done_pulse;
  logic [DATA_W-1:0] dq_s1_r;
  logic [DATA_W-1:0] dq_s2_r;

  assign is_read = (op_r == FCSU_OP_READ_WORD) ||
                   (second_r && (op_r == FCSU_OP_IDENT ||
                                 op_r == FCSU_OP_READ_STAT));
  assign done_pulse = state_r == FCSU_ST_DONE;

  // The data pins are asynchronous to our clock.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= flash_dq_i;
      dq_s2_r <= dq_s1_r;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r  <= FCSU_ST_IDLE;
      cnt_r    <= 8'h00;
      second_r <= 1'b0;
      busy_r   <= 1'b0;
    end else begin
      case (state_r)
        FCSU_ST_IDLE: if (go) begin
          state_r  <= FCSU_ST_SETUP;
          cnt_r    <= PHASE;
          second_r <= 1'b0;
          busy_r   <= 1'b1;
        end
        FCSU_ST_SETUP: if (cnt_r <= 8'h01) begin
          state_r <= FCSU_ST_STRB;
          cnt_r   <= PHASE;
        end else cnt_r <= cnt_r - 8'h01;
        FCSU_ST_STRB: if (cnt_r <= 8'h01) begin
          state_r <= FCSU_ST_HOLD;
          cnt_r   <= PHASE;
        end else cnt_r <= cnt_r - 8'h01;
        FCSU_ST_HOLD: if (cnt_r <= 8'h01) begin
          state_r <= FCSU_ST_GAP;
          cnt_r   <= PHASE;
        end else cnt_r <= cnt_r - 8'h01;
        FCSU_ST_GAP: if (cnt_r <= 8'h01) begin
          if (!second_r && two_cycles(op_r)) begin
            second_r <= 1'b1;
            state_r  <= FCSU_ST_SETUP;
            cnt_r    <= PHASE;
          end else state_r <= FCSU_ST_DONE;
        end else cnt_r <= cnt_r - 8'h01;
        FCSU_ST_DONE: begin
          state_r <= FCSU_ST_IDLE;
          busy_r  <= 1'b0;
        end
        default: state_r <= FCSU_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive.  Address, data and chip enable are held through the
  // hold phase so the device latches them on the strobe's rising edge.

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flash_addr  <= '0;
      flash_dq_o  <= '0;
      flash_dq_oe <= 1'b0;
      flash_ce_n  <= 1'b1;
      flash_oe_n  <= 1'b1;
      flash_we_n  <= 1'b1;
    end else begin
      flash_ce_n <= !(state_r == FCSU_ST_SETUP || state_r == FCSU_ST_STRB
                      || state_r == FCSU_ST_HOLD);
      flash_we_n <= !(state_r == FCSU_ST_STRB && !is_read);
      flash_oe_n <= !(state_r == FCSU_ST_STRB && is_read);
      flash_dq_oe <= (state_r == FCSU_ST_SETUP || state_r == FCSU_ST_STRB
                      || state_r == FCSU_ST_HOLD) && !is_read;
      flash_addr <= addr_r;
      if (second_r && op_r == FCSU_OP_PROGRAM)
        flash_dq_o <= wdata_r;
      else if (second_r && op_r == FCSU_OP_ERASE)
        flash_dq_o <= DATA_W'(`FCSU_CMD_CONFIRM);
      else
        flash_dq_o <= DATA_W'(first_code(op_r));
      if (second_r && op_r == FCSU_OP_IDENT)
        flash_addr <= {addr_r[ADDR_W-1:1], addr_r[0]};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reset_powerdown_n <= 1'b0;
      flash_wp_n        <= 1'b0;
    end else begin
      reset_powerdown_n <= pins_r[0];
      flash_wp_n        <= pins_r[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture.  The sample is taken at the end of the output-enable phase,
  // once the synchroniser has had two clock cycles' worth of settling.

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rword_r  <= '0;
      status_r <= 8'h00;
    end else if (state_r == FCSU_ST_HOLD && cnt_r == PHASE && is_read) begin
      rword_r <= dq_s2_r;
      if (op_r == FCSU_OP_READ_STAT)
        status_r <= dq_s2_r[7:0] & `FCSU_SR_USED_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupts: 0 done, 1 error bits seen, 2 erase paused, 3 voltage low.
  // Errors are only reported once the ready bit says the engine is idle.

  logic       stat_cap;
  logic [3:0] ev;

  assign stat_cap = done_pulse && op_r == FCSU_OP_READ_STAT &&
                    status_r[`FCSU_SR_READY];
  assign ev = {stat_cap && status_r[`FCSU_SR_VPP_LOW],
               stat_cap && status_r[`FCSU_SR_PAUSED],
               stat_cap && (status_r[`FCSU_SR_ERASE_ERR] ||
                            status_r[`FCSU_SR_PROG_ERR]),
               done_pulse};

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ist_r <= 4'h0;
    end else begin
      // A new event wins over a write-one clear in the same cycle.
      ist_r <= (ist_r & ~((wr_hit && wb_adr_i == `FCSU_OFS_IRQ_STAT)
                          ? wb_dat_i[3:0] : 4'h0)) | ev;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ist_r & imask_r);
    end
  end

endmodule : fcsu_ctrl

`default_nettype wire

// ==== test/fcsu_ctrl_sva.sv ====
// Checker for the controller's Wishbone answer and flash strobe timing.
// Sees only the controller's ports; the bind follows the module.
`timescale 1ns/1ns
`default_nettype none
module fcsu_ctrl_chk #(
  parameter int ADDR_W = 20,
  parameter int DATA_W = 16
) (
  // System.
  input wire logic              clock,
  input wire logic              reset,
  // Wishbone.
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  // Flash pins.
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_o,
  input wire logic              flash_dq_oe,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_strobe;
    !flash_we_n [*3] ##1 flash_we_n;
  endsequence
  sequence s_setup;
    (flash_we_n && flash_oe_n) [*3];
  endsequence
  chk_ack_follows: assert property (s_take |=> wb_ack_o)
    else $error("no ack after a taken request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  chk_we_width: assert property ($fell(flash_we_n) |-> s_strobe)
    else $error("write strobe not three cycles long");
  chk_we_in_ce: assert property (
    !flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe outside chip select");
  chk_ce_setup: assert property ($fell(flash_ce_n) |-> s_setup)
    else $error("strobe inside the setup phase");
  chk_data_held: assert property (
    !flash_we_n |-> flash_dq_oe && $stable(flash_dq_o) && $stable(flash_addr))
    else $error("address or data moved under the write strobe");
  chk_read_float: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("controller drives data during a read");
endmodule : fcsu_ctrl_chk

bind fcsu_ctrl fcsu_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
`default_nettype wire

// ==== test/fcsu_flash_model.sv ====
// Behavioural boot-block flash: command decode, status byte, memory.
// Assumes the bench resolves the shared data pins around it.
`timescale 1ns/1ns
`default_nettype none
module fcsu_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h005A, // Arbitrary value.
  parameter logic [15:0] PART_CODE  = 16'h0A5A, // Arbitrary value.
  parameter logic [19:0] BOOT_BASE  = 20'hF8000,
  parameter int          PROG_T     = 5,
  parameter int          ERASE_T    = 300
) (
  // Pins from the controller.
  input  wire logic [19:0] addr,
  input  wire logic [15:0] dq_in,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rp_n,
  input  wire logic        wp_n,
  // Supply condition set by the bench.
  input  wire logic        vpp_ok,
  // Data towards the controller.
  output var  logic [15:0] dq_out
);
  logic [7:0]  sr = 8'h80;
  logic [7:0]  last = 8'h00;
  logic [1:0]  mode = 2'h0;
  logic        run = 1'h0;
  logic [15:0] shown = 16'h0000;
  logic [15:0] mem [int];
  int          rem = 0;
  ////////////////////////////////////////////////////////////////
  // The engine counts down in 40 ns ticks; a paused erase keeps rem.
  always #40 if (run && rem > 0) begin
    rem--;
    if (rem == 0) begin
      run = 1'h0;
      sr[7] = 1'h1;
    end
  end
  always @(negedge rp_n) begin
    sr = 8'h80;
    mode = 2'h0;
    run = 1'h0;
    last = 8'h00;
  end
  always @(posedge we_n) if (!ce_n && rp_n) begin
    if (last == 8'h40 || last == 8'h10) begin
      if (!vpp_ok) sr |= 8'h18;
      else if (addr >= BOOT_BASE && !wp_n) sr |= 8'h10;
      else begin
        mem[addr] = dq_in;
        sr[7] = 1'h0;
        rem = PROG_T;
        run = 1'h1;
      end
      mode = 2'h2;
      last = 8'h00;
    end else if (last == 8'h20) begin
      if (dq_in[7:0] != 8'hD0) sr |= 8'h30;
      else if (!vpp_ok) sr |= 8'h28;
      else if (addr >= BOOT_BASE && !wp_n) sr |= 8'h20;
      else begin
        sr[7] = 1'h0;
        rem = ERASE_T;
        run = 1'h1;
      end
      mode = 2'h2;
      last = 8'h00;
    end else begin
      last = dq_in[7:0];
      case (dq_in[7:0])
        8'hFF: mode = 2'h0;
        8'h90: mode = 2'h1;
        8'h70: mode = 2'h2;
        8'h50: sr[5:3] = 3'h0;
        8'hB0: if (run) begin
          run = 1'h0;
          sr[7:6] = 2'h3;
          mode = 2'h2;
        end
        8'hD0: if (sr[6]) begin
          sr[7:6] = 2'h0;
          run = 1'h1;
        end
        default: ;
      endcase
    end
  end
  // A released bus shows the inverse of the last value, never a hold.
  always @(ce_n, oe_n, rp_n, addr, mode, sr) begin
    if (!ce_n && !oe_n && rp_n) begin
      if (mode == 2'h1) shown = addr[0] ? PART_CODE : MAKER_CODE;
      else if (mode == 2'h2) shown = {8'h00, sr};
      else shown = mem.exists(addr) ? mem[addr] : 16'hFFFF;
      dq_out = shown;
    end else dq_out = ~shown;
  end
endmodule : fcsu_flash_model
`default_nettype wire

// ==== test/fcsu_ctrl_bench.sv ====
// Self-checking bench for the flash command controller.
// Drives Wishbone, resolves the data pins and holds the flash model.
`timescale 1ns/1ns
`default_nettype none
module fcsu_ctrl_bench
  import fcsu_pkg::*;
;
  logic        clock = 1'h0;
  logic        reset = 1'h1;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we = 1'h0;
  logic        vpp_ok = 1'h1;
  logic [4:0]  adr = 5'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q, dat_o;
  logic        ack, irq, oe, ce_n, oe_n, we_n, rp_n, wp_n;
  logic [19:0] fa;
  logic [15:0] dq_o, m_dq, dq_bus;
  int          fail_count = 0;
  int          cmp_count = 0;
  assign dq_bus = oe ? dq_o : m_dq;
  always #20 clock = ~clock;
  fcsu_ctrl u_dut (.clock(clock), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq),
    .flash_addr(fa), .flash_dq_i(dq_bus), .flash_dq_o(dq_o),
    .flash_dq_oe(oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .reset_powerdown_n(rp_n), .flash_wp_n(wp_n));
  fcsu_flash_model u_flash (.addr(fa), .dq_in(dq_bus), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .wp_n(wp_n),
    .vpp_ok(vpp_ok), .dq_out(m_dq));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Ack is read before the edge's own updates land, as the slave sees it.
  task automatic bus(input logic w, input logic [4:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'h1 && n < 40);
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 40) chk("ack", 32'h1, 32'h0);
  endtask : bus
  task automatic op(input fcsu_op_t c, input logic [19:0] a);
    int n;
    n = 0;
    bus(1'h1, 5'h04, {12'h0, a});
    bus(1'h1, 5'h00, {23'h0, 1'h1, 4'h0, c});
    do begin
      bus(1'h0, 5'h0C, 32'h0);
      n++;
    end while (q[31] !== 1'h0 && n < 60);
    // A controller that never leaves busy must not slip through as a pass.
    if (n >= 60) chk("busy", 32'h0, 32'h1);
  endtask : op
  task automatic sr(input logic [7:0] e, input string nm);
    op(FCSU_OP_READ_STAT, 20'h0);
    chk(nm, {24'h0, e}, {24'h0, q[7:0]});
  endtask : sr
  task automatic t_regs;
    bus(1'h0, 5'h14, 32'h0);
    chk("mask reset", 32'h0, q);
    bus(1'h1, 5'h1C, 32'hFFFF_FFFF);
    bus(1'h0, 5'h1C, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'h1, 5'h18, 32'h3);
    bus(1'h0, 5'h18, 32'h0);
    chk("pins", 32'h3, q);
  endtask : t_regs
  task automatic t_ident;
    for (int i = 0; i < 2; i++) begin
      op(FCSU_OP_IDENT, 20'hABCD0 | 20'(i));
      chk("ident", i ? 32'h0A5A : 32'h005A, {16'h0, q[23:8]});
    end
  endtask : t_ident
  task automatic t_prog;
    bus(1'h1, 5'h08, 32'hA5C3);
    op(FCSU_OP_PROGRAM, 20'h00120);
    sr(8'h80, "prog ok");
    // The device stays in status mode after a program, so go back first.
    op(FCSU_OP_READ_ARRAY, 20'h0);
    op(FCSU_OP_READ_WORD, 20'h00120);
    chk("stored", 32'hA5C3, {16'h0, q[23:8]});
  endtask : t_prog
  task automatic t_lock;
    bus(1'h1, 5'h18, 32'h1);
    op(FCSU_OP_PROGRAM, 20'hF8010);
    sr(8'h90, "boot locked");
    repeat (3) @(posedge clock);
    chk("irq masked", 32'h0, {31'h0, irq});
    op(FCSU_OP_PROGRAM, 20'h00200);
    sr(8'h90, "error kept");
    op(FCSU_OP_READ_ARRAY, 20'h0);
    op(FCSU_OP_READ_WORD, 20'h00200);
    chk("main open", 32'hA5C3, {16'h0, q[23:8]});
    bus(1'h1, 5'h14, 32'h2);
    repeat (3) @(posedge clock);
    chk("irq raised", 32'h1, {31'h0, irq});
    op(FCSU_OP_CLEAR_STAT, 20'h0);
    sr(8'h80, "cleared");
    bus(1'h1, 5'h10, 32'hF);
    repeat (3) @(posedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'h1, 5'h18, 32'h3);
  endtask : t_lock
  task automatic t_vpp;
    vpp_ok <= 1'h0;
    op(FCSU_OP_PROGRAM, 20'h00300);
    sr(8'h98, "prog vpp");
    op(FCSU_OP_ERASE, 20'h00300);
    sr(8'hB8, "erase vpp");
    vpp_ok <= 1'h1;
    op(FCSU_OP_CLEAR_STAT, 20'h0);
    sr(8'h80, "vpp cleared");
  endtask : t_vpp
  task automatic t_susp;
    int n;
    op(FCSU_OP_ERASE, 20'h10000);
    sr(8'h00, "erasing");
    op(FCSU_OP_SUSPEND, 20'h0);
    sr(8'hC0, "paused");
    op(FCSU_OP_RESUME, 20'h0);
    sr(8'h00, "resumed");
    n = 0;
    do begin
      op(FCSU_OP_READ_STAT, 20'h0);
      n++;
    end while (q[7] !== 1'h1 && n < 40);
    chk("erase done", 32'h80, {24'h0, q[7:0]});
  endtask : t_susp
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    t_regs();
    t_ident();
    t_prog();
    t_lock();
    t_vpp();
    t_susp();
    wrap_up();
  end
  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end
endmodule : fcsu_ctrl_bench
`default_nettype wire
